/* logic/lmc_pkg.sv */
// Shared constants, command codes and step type of the LCD memory command block.
package lmc_pkg;
  // ----------------------------------------------------------------
  // Command codes
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_CURSOR_BASE = 8'hA0;
  localparam logic [7:0] CMD_CURSOR_MASK = 8'hF8;
  localparam logic [7:0] CMD_AUTO_WR = 8'hB0;
  localparam logic [7:0] CMD_AUTO_RD = 8'hB1;
  localparam logic [7:0] CMD_AUTO_END = 8'hB2;
  localparam logic [7:0] CMD_WR_INC = 8'hC0;
  localparam logic [7:0] CMD_RD_INC = 8'hC1;
  localparam logic [7:0] CMD_WR_DEC = 8'hC2;
  localparam logic [7:0] CMD_RD_DEC = 8'hC3;
  localparam logic [7:0] CMD_WR_KEEP = 8'hC4;
  localparam logic [7:0] CMD_RD_KEEP = 8'hC5;
  localparam logic [7:0] CMD_PEEK = 8'hE0;
  localparam logic [7:0] CMD_COPY = 8'hE8;
  localparam logic [7:0] CMD_BIT_BASE = 8'hF0;
  localparam logic [7:0] CMD_BIT_MASK = 8'hF0;
  localparam int BIT_SET_POS = 3;
  // ----------------------------------------------------------------
  // Geometry and reset values
  // ----------------------------------------------------------------
  localparam int ADDR_W = 16;
  localparam int LINE_BYTES = 20;
  localparam logic [2:0] CURSOR_LINES_RST = 3'h0;
  localparam logic [15:0] GFX_HOME_RST = 16'h0000;
  localparam logic [15:0] GFX_END_RST = 16'h7FFF;
  localparam logic [15:0] TXT_HOME_RST = 16'h8000;
  // Pointer step selectors.
  typedef enum logic [1:0] {LMC_STEP_INC, LMC_STEP_DEC, LMC_STEP_KEEP} lmc_step_e;
endpackage : lmc_pkg

/* logic/lmc_if.sv */
// Host-to-controller command and data port of the LCD memory command block.
`timescale 1ns/100ps
interface lmc_if;
  logic cmd_valid;   // One-cycle pulse: cmd_byte is a command.
  logic [7:0] cmd_byte;
  logic dat_valid;   // One-cycle pulse: host writes dat_byte.
  logic [7:0] dat_byte;
  logic rd_req;      // One-cycle pulse: host wants a data byte.
  logic rd_valid;    // One-cycle pulse: rd_byte holds the answer.
  logic [7:0] rd_byte;
  logic busy;        // High while the controller cannot take a request.
  logic peek_error_flag;
  logic [15:0] ptr_load;
  logic ptr_load_en; // One-cycle pulse: load the address pointer.
  modport dev (input cmd_valid, input cmd_byte, input dat_valid, input dat_byte,
    input rd_req, input ptr_load, input ptr_load_en,
    output rd_valid, output rd_byte, output busy, output peek_error_flag);
  modport host (output cmd_valid, output cmd_byte, output dat_valid, output dat_byte,
    output rd_req, output ptr_load, output ptr_load_en,
    input rd_valid, input rd_byte, input busy, input peek_error_flag);
endinterface : lmc_if

/* logic/lmc_device.sv */
// Controller end: command decoder, display memory access and refresh arbitration.
//
// Design decisions made here: strobed register access and the placing of the registers.
`timescale 1ns/100ps
module lmc_device #(
  parameter int MEM_DEPTH = 65536,
  parameter int LINE_LEN = lmc_pkg::LINE_BYTES
) (
  input wire logic clk,
  input wire logic sys_rst,
  lmc_if.dev hb,
  input wire logic cursor_enable,
  input wire logic [15:0] cursor_pos,
  input wire logic attr_mode,
  input wire logic [1:0] combine_op,
  input wire logic refresh_req,
  input wire logic [15:0] refresh_addr,
  output logic [7:0] refresh_data,
  output logic [2:0] cursor_lines,
  output logic cursor_show,
  output logic [15:0] cursor_at
);
  // Refuse sizes that the 16-bit pointer or the 8-bit line counter cannot serve.
  if (MEM_DEPTH < 2 || MEM_DEPTH > 65536 ||
      LINE_LEN < 1 || LINE_LEN > 255) begin : g_bad_param
    $error("lmc_device: unsupported parameter value");
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {ST_IDLE, ST_WAIT_OPND, ST_WRITE, ST_READ, ST_PEEK_T,
    ST_PEEK_G, ST_BIT_RD, ST_BIT_WR, ST_COPY_T, ST_COPY_G, ST_COPY_W} lmc_state_e;
  typedef struct packed {
    lmc_state_e st;
    logic auto_wr;
    logic auto_rd;
    logic [15:0] ptr;
    lmc_pkg::lmc_step_e step;
    logic [7:0] wdata;
    logic [7:0] tbyte;
    logic [7:0] bitcmd;
    logic [7:0] cnt;
    logic rd_valid;
    logic [7:0] rd_byte;
    logic peek_err;
    logic [2:0] cur_lines;
    logic cur_show;
    logic [15:0] cur_at;
    logic [7:0] rf_data;
  } lmc_dev_s;
  lmc_dev_s s_reg, s_next;
  logic [7:0] mem [0:MEM_DEPTH-1];

  // Step the pointer as the command asked.
  function automatic logic [15:0] step_ptr(logic [15:0] p, lmc_pkg::lmc_step_e k);
    unique case (k)
      lmc_pkg::LMC_STEP_INC: step_ptr = p + 16'h0001;
      lmc_pkg::LMC_STEP_DEC: step_ptr = p - 16'h0001;
      default: step_ptr = p;
    endcase
  endfunction : step_ptr

  // Combine text and graphic bytes as the panel shows them.
  function automatic logic [7:0] combine(logic [7:0] t, logic [7:0] g, logic [1:0] op);
    unique case (op)
      2'h1: combine = t ^ g;
      2'h2: combine = t & g;
      default: combine = t | g;
    endcase
  endfunction : combine

  logic in_gfx;
  logic mem_busy;
  logic [15:0] txt_addr;
  logic [15:0] mem_idx;
  logic [15:0] gfx_span;
  assign in_gfx = (s_reg.ptr >= lmc_pkg::GFX_HOME_RST) && (s_reg.ptr <= lmc_pkg::GFX_END_RST);
  assign gfx_span = s_reg.ptr - lmc_pkg::GFX_HOME_RST;
  assign txt_addr = lmc_pkg::TXT_HOME_RST + gfx_span;
  // Refresh owns the memory port in its cycle; host work simply waits.
  assign mem_busy = refresh_req;
  assign mem_idx = s_reg.ptr;

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    s_next = s_reg;
    s_next.rd_valid = 1'b0;
    // Cursor outputs track the enable and position.
    s_next.cur_show = cursor_enable;
    s_next.cur_at = cursor_pos;
    // Refresh read port: the byte stands one cycle after its address.
    s_next.rf_data = mem[refresh_addr];
    unique case (s_reg.st)
      ST_IDLE: begin
        if (hb.ptr_load_en) begin
          s_next.ptr = hb.ptr_load;
        end
        if (hb.cmd_valid) begin
          if (s_reg.auto_wr || s_reg.auto_rd) begin
            if (hb.cmd_byte == lmc_pkg::CMD_AUTO_END) begin
              s_next.auto_wr = 1'b0;
              s_next.auto_rd = 1'b0;
            end // Any other byte is dropped here.
          end else if ((hb.cmd_byte & lmc_pkg::CMD_CURSOR_MASK) == lmc_pkg::CMD_CURSOR_BASE) begin
            s_next.cur_lines = hb.cmd_byte[2:0];
          end else if (hb.cmd_byte == lmc_pkg::CMD_AUTO_WR) begin
            s_next.auto_wr = 1'b1;
          end else if (hb.cmd_byte == lmc_pkg::CMD_AUTO_RD) begin
            s_next.auto_rd = 1'b1;
          end else if (hb.cmd_byte inside {lmc_pkg::CMD_WR_INC, lmc_pkg::CMD_WR_DEC,
              lmc_pkg::CMD_WR_KEEP, lmc_pkg::CMD_RD_INC, lmc_pkg::CMD_RD_DEC,
              lmc_pkg::CMD_RD_KEEP}) begin
            // Bits 2:1 pick the step, bit 0 picks read.
            s_next.step = lmc_pkg::lmc_step_e'(hb.cmd_byte[2:1]);
            s_next.st = hb.cmd_byte[0] ? ST_READ : ST_WAIT_OPND;
          end else if (hb.cmd_byte == lmc_pkg::CMD_PEEK) begin
            if (!in_gfx) begin
              s_next.peek_err = 1'b1;
            end else begin
              s_next.peek_err = 1'b0;
              s_next.st = ST_PEEK_T;
            end
          end else if (hb.cmd_byte == lmc_pkg::CMD_COPY) begin
            // Attribute bytes live in the graphic area, so copy is refused.
            if (!attr_mode) begin
              s_next.cnt = 8'h00;
              s_next.st = ST_COPY_T;
            end
          end else if ((hb.cmd_byte & lmc_pkg::CMD_BIT_MASK) == lmc_pkg::CMD_BIT_BASE) begin
            s_next.bitcmd = hb.cmd_byte;
            s_next.st = ST_BIT_RD;
          end
        end else if (hb.dat_valid && s_reg.auto_wr) begin
          s_next.wdata = hb.dat_byte;
          s_next.step = lmc_pkg::LMC_STEP_INC;
          s_next.st = ST_WRITE;
        end else if (hb.rd_req && s_reg.auto_rd) begin
          s_next.step = lmc_pkg::LMC_STEP_INC;
          s_next.st = ST_READ;
        end
      end
      ST_WAIT_OPND: begin
        if (hb.dat_valid) begin
          s_next.wdata = hb.dat_byte;
          s_next.st = ST_WRITE;
        end
      end
      ST_WRITE: begin
        if (!mem_busy) begin
          s_next.ptr = step_ptr(s_reg.ptr, s_reg.step);
          s_next.st = ST_IDLE;
        end
      end
      ST_READ: begin
        if (!mem_busy) begin
          s_next.rd_byte = mem[mem_idx];
          s_next.rd_valid = 1'b1;
          s_next.ptr = step_ptr(s_reg.ptr, s_reg.step);
          s_next.st = ST_IDLE;
        end
      end
      ST_PEEK_T: begin
        if (!mem_busy) begin
          s_next.tbyte = mem[txt_addr];
          s_next.st = ST_PEEK_G;
        end
      end
      ST_PEEK_G: begin
        if (!mem_busy) begin
          s_next.rd_byte = combine(s_reg.tbyte, mem[mem_idx], combine_op);
          s_next.rd_valid = 1'b1;
          s_next.st = ST_IDLE;
        end
      end
      ST_BIT_RD: begin
        if (!mem_busy) begin
          s_next.wdata = mem[mem_idx];
          s_next.st = ST_BIT_WR;
        end
      end
      ST_BIT_WR: begin
        if (!mem_busy) begin
          s_next.wdata[s_reg.bitcmd[2:0]] = s_reg.bitcmd[lmc_pkg::BIT_SET_POS];
          s_next.st = ST_IDLE; // Pointer left alone.
        end
      end
      ST_COPY_T: begin
        if (!mem_busy) begin
          s_next.tbyte = mem[txt_addr];
          s_next.st = ST_COPY_G;
        end
      end
      ST_COPY_G: begin
        if (!mem_busy) begin
          s_next.wdata = combine(s_reg.tbyte, mem[mem_idx], combine_op);
          s_next.st = ST_COPY_W;
        end
      end
      ST_COPY_W: begin
        if (!mem_busy) begin
          s_next.ptr = s_reg.ptr + 16'h0001;
          s_next.cnt = s_reg.cnt + 8'h01;
          s_next.st = (s_reg.cnt == 8'(LINE_LEN - 1)) ? ST_IDLE : ST_COPY_T;
        end
      end
      // Unused state codes fall back to idle rather than hang the port.
      default: begin
        s_next.st = ST_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Registers and memory port
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_reg <= '0;
      s_reg.cur_lines <= lmc_pkg::CURSOR_LINES_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  // Single write port; refresh reads win the slot.
  always_ff @(posedge clk) begin
    if (!mem_busy && (s_reg.st == ST_WRITE || s_reg.st == ST_COPY_W)) begin
      mem[mem_idx] <= s_reg.wdata;
    end else if (!mem_busy && s_reg.st == ST_BIT_WR) begin
      mem[mem_idx] <= s_next.wdata;
    end
  end

  assign hb.rd_valid = s_reg.rd_valid;
  assign hb.rd_byte = s_reg.rd_byte;
  assign hb.busy = (s_reg.st != ST_IDLE) && (s_reg.st != ST_WAIT_OPND);
  assign hb.peek_error_flag = s_reg.peek_err;
  assign refresh_data = s_reg.rf_data;
  assign cursor_lines = s_reg.cur_lines;
  assign cursor_show = s_reg.cur_show;
  assign cursor_at = s_reg.cur_at;
endmodule : lmc_device

/* logic/lmc_host.sv */
// Host end: turns simple user requests into command and data pulses.
`timescale 1ns/100ps
module lmc_host (
  input wire logic clk,
  input wire logic sys_rst,
  lmc_if.host hb,
  input wire logic u_cmd,
  input wire logic [7:0] u_cmd_byte,
  input wire logic u_dat,
  input wire logic [7:0] u_dat_byte,
  input wire logic u_rd,
  input wire logic u_ptr,
  input wire logic [15:0] u_ptr_val,
  output logic u_ready,
  output logic u_rd_valid,
  output logic [7:0] u_rd_byte,
  output logic u_peek_err
);
  typedef struct packed {
    logic cmd_v;
    logic [7:0] cmd_b;
    logic dat_v;
    logic [7:0] dat_b;
    logic rd;
    logic pl;
    logic [15:0] pv;
    logic rv;
    logic [7:0] rb;
    logic pe;
  } lmc_host_s;
  lmc_host_s s_reg, s_next;

  // ----------------------------------------------------------------
  // Request issue: one pulse per user request, held off while busy.
  // ----------------------------------------------------------------
  always_comb begin
    s_next = '0;
    s_next.rb = s_reg.rb;
    s_next.pe = hb.peek_error_flag;
    if (!hb.busy && !s_reg.cmd_v && !s_reg.dat_v && !s_reg.rd) begin
      s_next.pl = u_ptr;
      s_next.pv = u_ptr_val;
      s_next.cmd_v = u_cmd;
      s_next.cmd_b = u_cmd_byte;
      s_next.dat_v = u_dat && !u_cmd;
      s_next.dat_b = u_dat_byte;
      s_next.rd = u_rd && !u_cmd && !u_dat;
    end
    if (hb.rd_valid) begin
      s_next.rv = 1'b1;
      s_next.rb = hb.rd_byte;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign hb.cmd_valid = s_reg.cmd_v;
  assign hb.cmd_byte = s_reg.cmd_b;
  assign hb.dat_valid = s_reg.dat_v;
  assign hb.dat_byte = s_reg.dat_b;
  assign hb.rd_req = s_reg.rd;
  assign hb.ptr_load_en = s_reg.pl;
  assign hb.ptr_load = s_reg.pv;
  assign u_ready = !s_reg.cmd_v && !s_reg.dat_v && !s_reg.rd;
  assign u_rd_valid = s_reg.rv;
  assign u_rd_byte = s_reg.rb;
  assign u_peek_err = s_reg.pe;
endmodule : lmc_host

/* testbench/lmc_props.sv */
// Concurrent checks on the port that joins the host and controller ends.
`timescale 1ns/100ps
module lmc_props (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_byte,
  input wire logic dat_valid,
  input wire logic rd_req,
  input wire logic rd_valid,
  input wire logic busy,
  input wire logic peek_error_flag,
  input wire logic [15:0] ptr_load,
  input wire logic ptr_load_en
);
  logic auto_reg;
  logic [15:0] ptr_reg;
  logic take;
  assign take = cmd_valid && !busy;
  // Shadow of auto mode and of the last loaded pointer.
  // Limitation: peeks are judged against the last loaded pointer; pointer steps made since that load are not followed.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      auto_reg <= 1'b0;
      ptr_reg <= 16'h0000;
    end else begin
      if (take && (cmd_byte == 8'hB0 || cmd_byte == 8'hB1)) begin
        auto_reg <= 1'b1;
      end else if (take && cmd_byte == 8'hB2) begin
        auto_reg <= 1'b0;
      end
      if (ptr_load_en) begin
        ptr_reg <= ptr_load;
      end
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  property p_rd_cmd;
    take && !auto_reg && cmd_byte inside {8'hC1, 8'hC3, 8'hC5} |-> ##[2:10] rd_valid;
  endproperty
  a_rd_cmd: assert property (p_rd_cmd) else $error("single read not answered");
  property p_auto_rd;
    rd_req && auto_reg && !busy |-> ##[2:10] rd_valid;
  endproperty
  a_auto_rd: assert property (p_auto_rd) else $error("auto read not answered");
  property p_auto_mute;
    take && auto_reg && cmd_byte != 8'hB2 |=> !rd_valid [*2];
  endproperty
  a_auto_mute: assert property (p_auto_mute) else $error("command ran in auto mode");
  property p_peek_bad;
    take && !auto_reg && cmd_byte == 8'hE0 && ptr_reg[15] |-> ##[1:6] peek_error_flag;
  endproperty
  a_peek_bad: assert property (p_peek_bad) else $error("peek error not flagged");
  property p_peek_ok;
    take && !auto_reg && cmd_byte == 8'hE0 && !ptr_reg[15] |-> ##[3:10] rd_valid;
  endproperty
  a_peek_ok: assert property (p_peek_ok) else $error("peek not answered");
  property p_rd_once;
    rd_valid |=> !rd_valid;
  endproperty
  a_rd_once: assert property (p_rd_once) else $error("answer longer than a cycle");
  property p_rd_after_busy;
    rd_valid |-> $past(busy);
  endproperty
  a_rd_after_busy: assert property (p_rd_after_busy) else $error("answer without work");
  property p_wr_mute;
    dat_valid |=> !rd_valid [*2];
  endproperty
  a_wr_mute: assert property (p_wr_mute) else $error("write gave an answer");
  property p_busy_bound;
    busy |-> ##[1:40] !busy;
  endproperty
  a_busy_bound: assert property (p_busy_bound) else $error("busy stuck");
  c_auto_rd: cover property (take && cmd_byte == 8'hB1);
  c_peek_err: cover property ($rose(peek_error_flag));
  c_bit_op: cover property (take && cmd_byte[7:4] == 4'hF);
endmodule : lmc_props

/* testbench/lcd_memory_access_commands_test.sv */
// Self-checking bench joining the host and controller ends of the command port.
`timescale 1ns/100ps
module lcd_memory_access_commands_test;
  localparam logic [3:0] CM = 4'h1, DT = 4'h2, RD = 4'h4, PT = 4'h8;
  logic clk, sys_rst, cur_en, attr, rf_req, u_ready, u_rd_valid, u_peek_err, cursor_show;
  logic [3:0] ureq;
  logic [15:0] uval, cur_pos, rf_addr, cursor_at;
  logic [1:0] comb;
  logic [7:0] u_rd_byte, refresh_data;
  logic [2:0] cursor_lines;
  int n_fail, tests_run;
  int cyc = 0;
  lmc_if lif ();
  lmc_host u_lmc_host (.clk(clk), .sys_rst(sys_rst), .hb(lif.host), .u_cmd(ureq[0]),
    .u_cmd_byte(uval[7:0]), .u_dat(ureq[1]), .u_dat_byte(uval[7:0]), .u_rd(ureq[2]),
    .u_ptr(ureq[3]), .u_ptr_val(uval), .u_ready(u_ready), .u_rd_valid(u_rd_valid),
    .u_rd_byte(u_rd_byte), .u_peek_err(u_peek_err));
  lmc_device #(.LINE_LEN(4)) u_lmc_device (.clk(clk), .sys_rst(sys_rst), .hb(lif.dev),
    .cursor_enable(cur_en), .cursor_pos(cur_pos), .attr_mode(attr), .combine_op(comb),
    .refresh_req(rf_req), .refresh_addr(rf_addr), .refresh_data(refresh_data),
    .cursor_lines(cursor_lines), .cursor_show(cursor_show), .cursor_at(cursor_at));
  lmc_props u_lmc_props (.clk(clk), .sys_rst(sys_rst), .cmd_valid(lif.cmd_valid),
    .cmd_byte(lif.cmd_byte), .dat_valid(lif.dat_valid), .rd_req(lif.rd_req),
    .rd_valid(lif.rd_valid), .busy(lif.busy), .peek_error_flag(lif.peek_error_flag),
    .ptr_load(lif.ptr_load), .ptr_load_en(lif.ptr_load_en));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Refresh takes every other slot, so host accesses must wait their turn.
  always @(posedge clk) begin
    rf_req <= ~rf_req & ~sys_rst;
    // Refresh scans the four bytes of the first auto block, so its data is checkable.
    rf_addr <= {14'h0080, cyc[1:0]};
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_fail++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish();
    $display("checks=%0d mismatches=%0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // Hold a user request until the host end can take it; readiness is seen at the falling edge.
  task automatic req(input logic [3:0] k, input logic [15:0] v);
    int n;
    @(posedge clk);
    ureq <= k;
    uval <= v;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (!(u_ready === 1'b1 && lif.busy === 1'b0) && n < 100);
    if (n == 100) n_fail++;
    @(posedge clk);
    ureq <= 4'h0;
  endtask : req
  task automatic get(input logic [7:0] exp);
    int n;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (u_rd_valid !== 1'b1 && n < 100);
    // A missing answer must not pass on a stale byte.
    if (u_rd_valid !== 1'b1) n_fail++;
    chk(u_rd_byte, exp);
  endtask : get
  initial begin
    int i;
    logic [7:0] b;
    sys_rst = 1'b1;
    cur_en = 1'b0;
    attr = 1'b0;
    ureq = 4'h0;
    uval = 16'h0000;
    cur_pos = 16'h0000;
    comb = 2'h0;
    n_fail = 0;
    tests_run = 0;
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    @(negedge clk);
    chk({5'h00, cursor_lines}, 8'h00);
    // Every cursor code, then cursor enable and position following the inputs.
    for (i = 0; i < 8; i++) begin
      req(CM, 16'h00A0 + i[15:0]);
      repeat (4) @(negedge clk);
      chk({5'h00, cursor_lines}, i[7:0]);
    end
    for (i = 0; i < 2; i++) begin
      @(posedge clk);
      cur_en <= i[0];
      cur_pos <= 16'h0123 + i[15:0];
      repeat (3) @(negedge clk);
      chk({7'h00, cursor_show}, {7'h00, i[0]});
      chk(cursor_at[7:0], 8'h23 + i[7:0]);
    end
    // Single-byte writes and reads; each pointer step decides where the next byte lands.
    req(PT, 16'h0100);
    req(CM, 16'h00C0);
    req(DT, 16'h005A);
    req(CM, 16'h00C2);
    req(DT, 16'h00A5);
    req(CM, 16'h00C4);
    req(DT, 16'h003C);
    req(CM, 16'h00C5);
    get(8'h3C);
    req(CM, 16'h00C1);
    get(8'h3C);
    req(CM, 16'h00C3);
    get(8'hA5);
    req(CM, 16'h00C5);
    get(8'h3C);
    // Auto block write, then auto read with foreign commands thrown in mid-block.
    req(PT, 16'h0200);
    req(CM, 16'h00B0);
    for (i = 0; i < 4; i++) req(DT, 16'h0030 + i[15:0]);
    req(CM, 16'h00B2);
    req(PT, 16'h0200);
    req(CM, 16'h00B1);
    for (i = 0; i < 4; i++) begin
      req(RD, 16'h0000);
      get(8'h30 + i[7:0]);
      if (i == 1) begin
        req(CM, 16'h00C1);
        req(CM, 16'h00FF);
        req(CM, 16'h00A3);
      end
    end
    req(CM, 16'h00B2);
    repeat (4) @(negedge clk);
    chk({5'h00, cursor_lines}, 8'h07);
    // Refresh data trails its address by one cycle and is not disturbed by host work.
    repeat (2) begin
      @(negedge clk);
      chk(refresh_data, 8'h30 + {6'h00, rf_addr[1:0] - 2'h1});
    end
    // All sixteen bit codes on one byte, read back in place after each.
    req(PT, 16'h0300);
    req(CM, 16'h00C4);
    req(DT, 16'h005A);
    b = 8'h5A;
    for (i = 0; i < 16; i++) begin
      req(CM, 16'h00F0 + i[15:0]);
      b[i[2:0]] = i[3];
      req(CM, 16'h00C5);
      get(b);
    end
    // Peek outside the graphic area, then inside it in each combine mode.
    req(PT, 16'h8005);
    req(CM, 16'h00C4);
    req(DT, 16'h00C6);
    req(CM, 16'h00E0);
    repeat (8) @(negedge clk);
    chk({6'h00, u_peek_err, lif.peek_error_flag}, 8'h03);
    req(PT, 16'h0005);
    req(CM, 16'h00C4);
    req(DT, 16'h00A3);
    for (i = 0; i < 3; i++) begin
      @(posedge clk);
      comb <= i[1:0];
      req(PT, 16'h0005);
      req(CM, 16'h00E0);
      get(i == 0 ? 8'hE7 : (i == 1 ? 8'h65 : 8'h82));
    end
    chk({6'h00, u_peek_err, lif.peek_error_flag}, 8'h00);
    // Copy one four-byte line in AND mode: text 11,22,44,88 over graphics 0F.
    req(PT, 16'h8400);
    req(CM, 16'h00B0);
    for (i = 0; i < 4; i++) req(DT, {8'h00, 8'h11 << i});
    req(CM, 16'h00B2);
    req(PT, 16'h0400);
    req(CM, 16'h00B0);
    for (i = 0; i < 4; i++) req(DT, 16'h000F);
    req(CM, 16'h00B2);
    req(PT, 16'h0400);
    req(CM, 16'h00E8);
    req(PT, 16'h0400);
    req(CM, 16'h00B1);
    for (i = 0; i < 4; i++) begin
      req(RD, 16'h0000);
      get(8'h01 << i);
    end
    req(CM, 16'h00B2);
    // Copy with attributes on must leave the graphic byte alone.
    @(posedge clk);
    attr <= 1'b1;
    req(PT, 16'h0005);
    req(CM, 16'h00E8);
    req(CM, 16'h00C5);
    get(8'hA3);
    tally_and_finish();
  end
endmodule : lcd_memory_access_commands_test
